/* File: dv/sadc_link_asserts.sv */
// Purpose: Link checks between the host end and the converter device end
// Assumes: All link signals are sampled on core_clk; reset_n is active low
// Notes: Edge and run-length counters are helper registers, not design state
`timescale 1ns/100ps
module sadc_link_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic conversion_strobe,
  input wire logic sclk,
  input wire logic data_o,
  input wire logic data_oe_n,
  input wire logic data_line
);
  import sadc_pkg::*;
  // Acquisition time and hold droop limit in core cycles
  localparam int ACQ_MIN = int'(ACQ_CYC);
  localparam int DRP_MAX = DRP_CYC;
  logic strobe_q_r, strobe_q_nxt, sclk_q_r, sclk_q_nxt, sclk_fall;
  logic [4:0] fall_cnt_r, fall_cnt_nxt, hi_cnt_r, hi_cnt_nxt;
  logic [7:0] low_cnt_r, low_cnt_nxt, since_r, since_nxt;

  // Counters saturate so that long idle spans never wrap into false hits
  always_comb begin
    sclk_fall = sclk_q_r & ~sclk;
    strobe_q_nxt = conversion_strobe;
    sclk_q_nxt = sclk;
    fall_cnt_nxt = fall_cnt_r;
    if (strobe_q_r && !conversion_strobe) begin
      fall_cnt_nxt = 5'h00;
    end else if (sclk_fall && fall_cnt_r != 5'h1F) begin
      fall_cnt_nxt = fall_cnt_r + 5'h01;
    end
    hi_cnt_nxt = conversion_strobe ? ((hi_cnt_r == 5'h1F) ? hi_cnt_r : hi_cnt_r + 5'h01) : 5'h00;
    low_cnt_nxt = !sclk ? ((low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 8'h01) : 8'h00;
    since_nxt = sclk_fall ? 8'h01 : ((since_r == 8'hFF) ? since_r : since_r + 8'h01);
  end

  // Idle levels at reset avoid a phantom edge on release
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_q_r <= 1'b1;
      sclk_q_r <= 1'b1;
      fall_cnt_r <= 5'h1F;
      hi_cnt_r <= 5'h00;
      low_cnt_r <= 8'h00;
      since_r <= 8'hFF;
    end else begin
      strobe_q_r <= strobe_q_nxt;
      sclk_q_r <= sclk_q_nxt;
      fall_cnt_r <= fall_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      low_cnt_r <= low_cnt_nxt;
      since_r <= since_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_fall_hiz: assert property ($fell(conversion_strobe) |-> ##[0:5] data_oe_n)
    else $error("data line still driven after strobe fall");
  a_release_fall14: assert property (($fell(sclk) && fall_cnt_r == 5'h0D) |-> ##[1:5] data_oe_n)
    else $error("data line not released after clock fall 14");
  a_bit_on_fall: assert property (($changed(data_o) && !data_oe_n && !$past(data_oe_n))
    |-> since_r inside {[8'h01:8'h05]})
    else $error("data bit changed away from a clock fall");
  a_stable_rise: assert property (($rose(sclk) && !data_oe_n) |-> $stable(data_line))
    else $error("data line moved at the sampling clock rise");
  a_acq_min: assert property ($fell(conversion_strobe) |-> hi_cnt_r >= ACQ_MIN)
    else $error("strobe high shorter than acquisition time");
  a_strobe_low: assert property ($fell(conversion_strobe) |-> !conversion_strobe [*2])
    else $error("strobe low pulse too short");
  a_clock_start: assert property ($fell(conversion_strobe)
    |-> ##[1:DRP_MAX] ($fell(sclk) || conversion_strobe))
    else $error("clock not started within hold droop limit");
  a_period_max: assert property (low_cnt_r < 8'(CKP_MAX_CYC))
    else $error("serial clock low beyond period limit");
endmodule : sadc_link_asserts

/* File: dv/sar_adc_serial_mode_control_bench.sv */
// Purpose: Self-checking bench joining the host end and the device end over the link
// Assumes: 40 MHz core clock; the host makes the serial clock by division
// Notes: Link faults by the far party are not injected; the checker watches the wire
`timescale 1ns/100ps
module sar_adc_serial_mode_control_bench;
  import sadc_pkg::*;
  logic core_clk, reset_n, start, busy, h_valid, d_valid, d_hold, power_down, lsb_mode, aborted;
  logic [1:0] mode;
  logic [3:0] short_bits;
  logic [RES_BITS-1:0] sample_code, h_res, d_res, h_last, d_last, exp_w;
  int n_fail, n_checks, n_hv, n_dv, n_ab, n_pd, n_lsb, dv0, ab0, pd0, ls0;
  int n_hd, hd0, hv0;
  logic [11:0] codes [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h801};
  logic [3:0] nbs [3] = '{4'h1, 4'h4, 4'hB};

  sadc_link_if link ();
  sadc_dev sadc_dev_i (.link(link.dev), .core_clk(core_clk), .reset_n(reset_n),
    .sample_code(sample_code), .result(d_res), .result_valid(d_valid), .hold(d_hold),
    .power_down(power_down), .lsb_mode(lsb_mode), .aborted(aborted));
  sadc_host sadc_host_i (.link(link.host), .core_clk(core_clk), .reset_n(reset_n),
    .start(start), .mode(mode), .short_bits(short_bits), .busy(busy), .result(h_res),
    .result_valid(h_valid));
  sadc_link_asserts sadc_link_asserts_i (.core_clk(core_clk), .reset_n(reset_n),
    .conversion_strobe(link.conversion_strobe), .sclk(link.sclk), .data_o(link.data_o),
    .data_oe_n(link.data_oe_n), .data_line(link.data_line));

  // Core clock, 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Pulses stand one cycle, so they are counted mid-cycle, away from updates
  always @(negedge core_clk) begin
    if (h_valid === 1'b1) begin
      n_hv++;
      h_last = h_res;
    end
    if (d_valid === 1'b1) begin
      n_dv++;
      d_last = d_res;
    end
    if (aborted === 1'b1) n_ab++;
    if (power_down === 1'b1) n_pd++;
    if (lsb_mode === 1'b1) n_lsb++;
    if (d_hold === 1'b1) n_hd++;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One host frame; flags are read at the falling edge, away from updates
  task automatic frame(input logic [1:0] m, input logic [3:0] nb, input logic [11:0] code);
    int t;
    dv0 = n_dv;
    ab0 = n_ab;
    pd0 = n_pd;
    ls0 = n_lsb;
    hd0 = n_hd;
    hv0 = n_hv;
    @(posedge core_clk);
    sample_code <= code;
    mode <= m;
    short_bits <= nb;
    start <= 1'b1;
    t = 0;
    do begin
      @(negedge core_clk);
      t++;
    end while (busy !== 1'b1 && t < 200);
    @(posedge core_clk);
    start <= 1'b0;
    t = 0;
    do begin
      @(negedge core_clk);
      t++;
    end while (busy !== 1'b0 && t < 1000);
    check("frame ended", 12'(busy), 12'h000);
    repeat (10) @(negedge core_clk);
    check("host pulses", 12'(n_hv - hv0), 12'h001);
  endtask : frame

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Watchdog: 12 frames of under 500 cycles each, with wide margin
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("mismatch watchdog expected finish seen timeout");
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    start = 1'b0;
    mode = 2'h0;
    short_bits = 4'h0;
    sample_code = 12'h000;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge core_clk);
    // Normal frames back to back, corner codes included
    foreach (codes[i]) begin
      frame(HM_NORMAL, 4'h0, codes[i]);
      check("host result", h_last, codes[i]);
      check("device result", d_last, codes[i]);
      check("result pulses", 12'(n_dv - dv0), 12'h001);
      check("hold seen", 12'(n_hd - hd0 > 0), 12'h001);
      check("hold released", 12'(d_hold), 12'h000);
    end
    $display("test normal done");
    // Strobe kept low through the frame, then woken by the next rise
    frame(HM_PDOWN, 4'h0, 12'h5A3);
    check("power-down seen", 12'(n_pd - pd0 > 0), 12'h001);
    check("device awake", 12'(power_down), 12'h000);
    frame(HM_NORMAL, 4'h0, 12'h1E7);
    check("first after wake", h_last, 12'h1E7);
    $display("test power-down done");
    // Resend of the word with the low bit first
    frame(HM_LSBF, 4'h0, 12'h3A7);
    check("lsb mode seen", 12'(n_lsb - ls0 > 0), 12'h001);
    check("lsb power-down", 12'(n_pd - pd0 > 0), 12'h001);
    check("lsb resend word", h_last, 12'h3A7);
    frame(HM_NORMAL, 4'h0, 12'h64C);
    check("normal after lsb", h_last, 12'h64C);
    check("lsb mode left", 12'(lsb_mode), 12'h000);
    $display("test lsb-first done");
    // Short cycles at one bit, a middle count and the last legal count
    foreach (nbs[i]) begin
      frame(HM_SHORT, nbs[i], 12'hC3A);
      check("abort pulse", 12'(n_ab - ab0), 12'h001);
      check("no full result", 12'(n_dv - dv0), 12'h000);
      // The host reads two bits at least, so that acquisition time is kept
      exp_w = 12'hC3A >> (12 - ((nbs[i] < 4'h2) ? 4'h2 : nbs[i]));
      check("short word", h_last, exp_w);
    end
    frame(HM_NORMAL, 4'h0, 12'h9B1);
    check("normal after short", h_last, 12'h9B1);
    $display("test short-cycle done");
    close_out();
  end
endmodule : sar_adc_serial_mode_control_bench

/* File: rtl/sadc_dev.sv */
// Purpose: Device end: conversion sequencing and serial output of a 12-bit converter
// Assumes: sample_code is the digitised input, stable in the core clock domain
// Notes: Strobe and serial clock are pins, synchronised before use
// What this block does
// - Strobe low through conversion powers down at 13
// - Stay powered down until strobe rises
// - Host holds strobe high for acquisition time
// - First conversion after wake-up is valid
// - Conversion plus sampling takes 16 clock periods
// - Raise by cycle 12, lower in 13: LSB-first
// - LSB-first resends result over next 11 clocks
// - LSB-first powers down, wakes on strobe high
// - Raise then early lower aborts the conversion
// - Strobe falling puts data line high impedance
// - Host keeps strobe high until bit latched
// - Result coded as straight unsigned binary
// - Host starts clock promptly, bounded clock period
// - SPI host drives strobe, clock, reads data
// - Hold taken on strobe falling edge itself
// - Host starts clock within 5 us
// - Conversion start drives data low, cycle one
`timescale 1ns/100ps
module sadc_dev (
  sadc_link_if.dev link,
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [sadc_pkg::RES_BITS-1:0] sample_code,
  output logic [sadc_pkg::RES_BITS-1:0] result,
  output logic result_valid,
  output logic hold,
  output logic power_down,
  output logic lsb_mode,
  output logic aborted
);
  import sadc_pkg::*;

  // Output bit for cycle n of a normal frame: cycle 2 carries bit 11
  function automatic logic [3:0] msb_index(input logic [3:0] cyc);
    msb_index = 4'(CYC_LSB - cyc);
  endfunction : msb_index

  logic [1:0] pin_s;
  logic strobe_s;
  logic sclk_s;

  // Strobe and clock arrive from the host's domain
  sadc_sync #(.W(2)) sadc_sync_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din({link.conversion_strobe, link.sclk}),
    .dout(pin_s)
  );
  assign strobe_s = pin_s[1];
  assign sclk_s = pin_s[0];

  sadc_dst_e st_r, st_nxt;
  logic strobe_q_r, strobe_q_nxt;
  logic sclk_q_r, sclk_q_nxt;
  logic [3:0] cyc_r, cyc_nxt;
  logic [3:0] lsb_idx_r, lsb_idx_nxt;
  logic [RES_BITS-1:0] code_r, code_nxt;
  logic raised_r, raised_nxt;
  logic dout_r, dout_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [RES_BITS-1:0] result_r, result_nxt;
  logic valid_r, valid_nxt;
  logic hold_r, hold_nxt;
  logic pd_r, pd_nxt;
  logic lsbm_r, lsbm_nxt;
  logic abort_r, abort_nxt;
  logic s_rise;
  logic s_fall;
  logic k_fall;

  // Edges found on the synchronised copies
  assign s_rise = strobe_s & ~strobe_q_r;
  assign s_fall = ~strobe_s & strobe_q_r;
  assign k_fall = ~sclk_s & sclk_q_r;

  // Next-state logic of the conversion sequencer
  always_comb begin
    st_nxt = st_r;
    strobe_q_nxt = strobe_s;
    sclk_q_nxt = sclk_s;
    cyc_nxt = cyc_r;
    lsb_idx_nxt = lsb_idx_r;
    code_nxt = code_r;
    raised_nxt = raised_r;
    dout_nxt = dout_r;
    oe_n_nxt = oe_n_r;
    result_nxt = result_r;
    valid_nxt = 1'b0;
    hold_nxt = hold_r;
    pd_nxt = pd_r;
    lsbm_nxt = lsbm_r;
    abort_nxt = 1'b0;
    case (st_r)
      DST_SAMPLE: begin
        // Sampling; D0 of the last frame was already dropped at the clock fall ending cycle 13
        if (k_fall) begin
          oe_n_nxt = 1'b1;
        end
        if (s_fall) begin
          st_nxt = DST_HOLD;
          hold_nxt = 1'b1;
          code_nxt = sample_code;
          oe_n_nxt = 1'b1;
          raised_nxt = 1'b0;
          cyc_nxt = '0;
        end
      end
      DST_HOLD: begin
        // Waiting for the first clock fall after the hold
        if (s_rise) begin
          hold_nxt = 1'b0;
        end
        if (s_fall) begin
          hold_nxt = 1'b1;
          code_nxt = sample_code;
          oe_n_nxt = 1'b1;
        end else if (k_fall && hold_r) begin
          st_nxt = DST_CONVERSION_STROBE;
          cyc_nxt = CYC_FIRST;
          oe_n_nxt = 1'b0;
          dout_nxt = 1'b0;
        end
      end
      DST_CONVERSION_STROBE: begin
        if (s_rise && cyc_r <= CYC_RAISE_LAST) begin
          raised_nxt = 1'b1;
        end
        if (s_rise && pd_r) begin
          // Woken inside cycle 13: back to sampling at once
          st_nxt = DST_SAMPLE;
          pd_nxt = 1'b0;
          hold_nxt = 1'b0;
          oe_n_nxt = 1'b1;
        end else if (s_fall && raised_r && cyc_r < CYC_LSB) begin
          // Short cycle: the fall is also the hold of a new sample
          st_nxt = DST_HOLD;
          abort_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          code_nxt = sample_code;
          raised_nxt = 1'b0;
          cyc_nxt = '0;
        end else if (s_fall && raised_r) begin
          // Fall during cycle 13 selects the LSB-first resend
          st_nxt = DST_LSBF;
          lsbm_nxt = 1'b1;
          pd_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          lsb_idx_nxt = 4'h1;
        end else if (k_fall && cyc_r < CYC_LSB) begin
          cyc_nxt = cyc_r + 4'h1;
          dout_nxt = code_r[msb_index(cyc_r + 4'h1)];
          if (cyc_r + 4'h1 == CYC_LSB) begin
            result_nxt = code_r;
            valid_nxt = 1'b1;
            if (!raised_r && !strobe_s) begin
              pd_nxt = 1'b1;
            end
          end
        end else if (k_fall) begin
          // End of cycle 13: release the line, then sample or sleep
          oe_n_nxt = 1'b1;
          hold_nxt = 1'b0;
          st_nxt = pd_r ? DST_PDOWN : DST_SAMPLE;
        end
      end
      DST_LSBF: begin
        if (s_rise) begin
          // Normal operation resumes as soon as the strobe is high
          st_nxt = DST_SAMPLE;
          pd_nxt = 1'b0;
          lsbm_nxt = 1'b0;
          hold_nxt = 1'b0;
          oe_n_nxt = 1'b1;
        end else if (k_fall && lsb_idx_r <= LSB_REPEAT) begin
          dout_nxt = code_r[lsb_idx_r];
          oe_n_nxt = 1'b0;
          lsb_idx_nxt = lsb_idx_r + 4'h1;
        end else if (k_fall) begin
          oe_n_nxt = 1'b1;
          st_nxt = DST_PDOWN;
        end
      end
      DST_PDOWN: begin
        // Nothing but a strobe rise leaves power-down; no dummy conversion follows
        if (s_rise) begin
          st_nxt = DST_SAMPLE;
          pd_nxt = 1'b0;
          lsbm_nxt = 1'b0;
          hold_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = DST_SAMPLE;
        oe_n_nxt = 1'b1;
        hold_nxt = 1'b0;
        pd_nxt = 1'b0;
      end
    endcase
  end

  // State registers of the sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= DST_SAMPLE;
      strobe_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
      cyc_r <= '0;
      lsb_idx_r <= '0;
      code_r <= '0;
      raised_r <= 1'b0;
      dout_r <= 1'b0;
      oe_n_r <= 1'b1;
      result_r <= '0;
      valid_r <= 1'b0;
      hold_r <= 1'b0;
      pd_r <= 1'b0;
      lsbm_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      strobe_q_r <= strobe_q_nxt;
      sclk_q_r <= sclk_q_nxt;
      cyc_r <= cyc_nxt;
      lsb_idx_r <= lsb_idx_nxt;
      code_r <= code_nxt;
      raised_r <= raised_nxt;
      dout_r <= dout_nxt;
      oe_n_r <= oe_n_nxt;
      result_r <= result_nxt;
      valid_r <= valid_nxt;
      hold_r <= hold_nxt;
      pd_r <= pd_nxt;
      lsbm_r <= lsbm_nxt;
      abort_r <= abort_nxt;
    end
  end

  // All outputs straight from flip-flops
  assign link.data_o = dout_r;
  assign link.data_oe_n = oe_n_r;
  assign result = result_r;
  assign result_valid = valid_r;
  assign hold = hold_r;
  assign power_down = pd_r;
  assign lsb_mode = lsbm_r;
  assign aborted = abort_r;
endmodule : sadc_dev

/* File: rtl/sadc_host.sv */
// Purpose: Host end: drives strobe and serial clock, collects the result
// Assumes: Serial clock is divided from core_clk and stops high between frames
// Notes: Data is sampled on the rising edge that follows the device's change
`timescale 1ns/100ps
module sadc_host (
  sadc_link_if.host link,
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [1:0] mode,
  input wire logic [3:0] short_bits,
  output logic busy,
  output logic [sadc_pkg::RES_BITS-1:0] result,
  output logic result_valid
);
  import sadc_pkg::*;

  logic data_s;

  // Data pin is synchronised before the sampler reads it
  sadc_sync #(.W(1)) sadc_sync_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(link.data_line),
    .dout(data_s)
  );

  sadc_hst_e st_r, st_nxt;
  sadc_mode_e mode_r, mode_nxt;
  logic [3:0] nb_r, nb_nxt;
  logic [2:0] div_r, div_nxt;
  logic [4:0] k_r, k_nxt;
  logic [4:0] acq_r, acq_nxt;
  logic sclk_r, sclk_nxt;
  logic strobe_r, strobe_nxt;
  logic [RES_BITS-1:0] msb_r, msb_nxt;
  logic [RES_BITS-1:0] lsb_r, lsb_nxt;
  logic [RES_BITS-1:0] result_r, result_nxt;
  logic valid_r, valid_nxt;
  logic [4:0] lim;

  // Falls after which the frame stops; short frames stop after nb bits
  always_comb begin
    case (mode_r)
      HM_LSBF: lim = CYC_LSB_END;
      HM_SHORT: lim = 5'({1'b0, nb_r} + 5'h1);
      default: lim = CYC_TOTAL;
    endcase
  end

  // Next-state logic of strobe, clock divider and sampler
  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    nb_nxt = nb_r;
    div_nxt = div_r;
    k_nxt = k_r;
    acq_nxt = acq_r;
    sclk_nxt = sclk_r;
    strobe_nxt = strobe_r;
    msb_nxt = msb_r;
    lsb_nxt = lsb_r;
    result_nxt = result_r;
    valid_nxt = 1'b0;
    case (st_r)
      HST_IDLE: begin
        // Strobe low at least its minimum, then high for acquisition
        if (acq_r != ACQ_DONE) begin
          acq_nxt = acq_r + 5'h1;
        end
        if (acq_r >= CVL_CYC) begin
          strobe_nxt = 1'b1;
        end
        if (start && acq_r == ACQ_DONE) begin
          st_nxt = HST_RUN;
          strobe_nxt = 1'b0;
          mode_nxt = sadc_mode_e'(mode);
          // One clock period of strobe high is below the acquisition time: two bits at least
          if (short_bits < 4'h2) begin
            nb_nxt = 4'h2;
          end else if (short_bits > LSB_REPEAT) begin
            nb_nxt = LSB_REPEAT;
          end else begin
            nb_nxt = short_bits;
          end
          div_nxt = '0;
          k_nxt = '0;
          msb_nxt = '0;
          lsb_nxt = '0;
        end
      end
      HST_RUN: begin
        // Clock starts in the first half period after the strobe falls
        if (div_r != HALF_CYC - 3'h1) begin
          div_nxt = div_r + 3'h1;
        end else begin
          div_nxt = '0;
          sclk_nxt = ~sclk_r;
          if (sclk_r) begin
            k_nxt = k_r + 5'h1;
          end else begin
            // Rising edge: the device changed data at the fall before
            if (k_r >= 5'h2 && k_r <= 5'(CYC_LSB)) begin
              msb_nxt = {msb_r[RES_BITS-2:0], data_s};
            end
            if (k_r >= 5'(CYC_LSB) && k_r <= CYC_LSB_END) begin
              lsb_nxt = {data_s, lsb_r[RES_BITS-1:1]};
            end
            // Raised in cycle one so a short frame still gives the acquisition time
            if (mode_r != HM_PDOWN && k_r == 5'h1) begin
              strobe_nxt = 1'b1;
            end
            // Strobe drops only after the bit on the line was latched
            if ((mode_r == HM_LSBF && k_r == 5'(CYC_LSB)) ||
                (mode_r == HM_SHORT && k_r == lim)) begin
              strobe_nxt = 1'b0;
            end
            if (k_r == lim) begin
              st_nxt = HST_IDLE;
              valid_nxt = 1'b1;
              // Normal frames end after D0 is in; LSB-first and short frames take their last bit here
              if (mode_r == HM_LSBF) begin
                result_nxt = {data_s, lsb_r[RES_BITS-1:1]};
              end else if (mode_r == HM_SHORT) begin
                result_nxt = {msb_r[RES_BITS-2:0], data_s};
              end else begin
                result_nxt = msb_r;
              end
              acq_nxt = (strobe_nxt) ? CVL_CYC : 5'h0;
            end
          end
        end
      end
      default: begin
        st_nxt = HST_IDLE;
        strobe_nxt = 1'b1;
        sclk_nxt = 1'b1;
      end
    endcase
  end

  // Registers of the host sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= HST_IDLE;
      mode_r <= HM_NORMAL;
      nb_r <= '0;
      div_r <= '0;
      k_r <= '0;
      acq_r <= CVL_CYC;
      sclk_r <= 1'b1;
      strobe_r <= 1'b1;
      msb_r <= '0;
      lsb_r <= '0;
      result_r <= '0;
      valid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      nb_r <= nb_nxt;
      div_r <= div_nxt;
      k_r <= k_nxt;
      acq_r <= acq_nxt;
      sclk_r <= sclk_nxt;
      strobe_r <= strobe_nxt;
      msb_r <= msb_nxt;
      lsb_r <= lsb_nxt;
      result_r <= result_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign link.conversion_strobe = strobe_r;
  assign link.sclk = sclk_r;
  assign busy = (st_r == HST_RUN);
  assign result = result_r;
  assign result_valid = valid_r;
endmodule : sadc_host

/* File: rtl/sadc_link_if.sv */
// Purpose: Serial link between host and converter device
// Assumes: Host drives strobe and serial clock, device drives a three-state data line
// Notes: The data wire is resolved here with a pull-up when nobody drives it
`timescale 1ns/100ps
interface sadc_link_if;
  logic conversion_strobe;
  logic sclk;
  logic data_o;
  logic data_oe_n;
  logic data_line;
  // Pull-up on the data wire; low enable means the device drives
  assign data_line = data_oe_n ? 1'b1 : data_o;
  modport dev (input conversion_strobe, input sclk, output data_o, output data_oe_n);
  modport host (output conversion_strobe, output sclk, input data_line);
endinterface : sadc_link_if

/* File: rtl/sadc_pkg.sv */
// Purpose: Shared constants and types for the converter link, device and host ends
// Assumes: Core clock of 40 MHz on both ends
// Notes: Times are kept in their own unit; cycle counts derive from them
package sadc_pkg;
  localparam int RES_BITS = 12;
  localparam int CLK_NS = 25;
  // Serial cycle numbers within one conversion
  localparam logic [3:0] CYC_FIRST = 4'h1;
  localparam logic [3:0] CYC_RAISE_LAST = 4'hC;
  localparam logic [3:0] CYC_LSB = 4'hD;
  localparam logic [3:0] LSB_REPEAT = 4'hB;
  localparam logic [4:0] CYC_TOTAL = 5'h10;
  localparam logic [4:0] CYC_LSB_END = 5'h18;
  // Host timing, least times round up, longest round down
  localparam int ACQ_NS = 350;
  localparam int CVL_NS = 40;
  localparam int SCLK_HALF_NS = 150;
  localparam int CKP_MAX_NS = 5000;
  localparam int DRP_US = 5;
  localparam logic [4:0] ACQ_CYC = 5'((ACQ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] CVL_CYC = 5'((CVL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] ACQ_DONE = ACQ_CYC + CVL_CYC;
  localparam logic [2:0] HALF_CYC = 3'(SCLK_HALF_NS / CLK_NS);
  localparam int DRP_CYC = (DRP_US * 1000) / CLK_NS;
  localparam int CKP_MAX_CYC = CKP_MAX_NS / CLK_NS;
  // Device sequencing states
  typedef enum logic [2:0] {
    DST_SAMPLE = 3'b000,
    DST_HOLD = 3'b001,
    DST_CONVERSION_STROBE = 3'b010,
    DST_LSBF = 3'b011,
    DST_PDOWN = 3'b100
  } sadc_dst_e;
  // Host modes of one conversion
  typedef enum logic [1:0] {
    HM_NORMAL = 2'b00,
    HM_PDOWN = 2'b01,
    HM_LSBF = 2'b10,
    HM_SHORT = 2'b11
  } sadc_mode_e;
  typedef enum logic [0:0] {
    HST_IDLE = 1'b0,
    HST_RUN = 1'b1
  } sadc_hst_e;
endpackage : sadc_pkg

/* File: rtl/sadc_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are levels from outside the core clock domain
// Notes: Only the second stage may be read by logic
`timescale 1ns/100ps
module sadc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
  assign dout = sync_r;
endmodule : sadc_sync
